/* radio_status_and_regulator_ctl.v */
`timescale 1ns/1ps
`include "radio_status_regs_defs.vh"
module radio_status_and_regulator_ctl #(
   parameter CNT_W = 7,
   parameter DLY_W = 4
) (
   // Clock and reset
   input  wire             clk,
   input  wire             srst,
   // Register port
   input  wire [15:0]      addr,
   input  wire [7:0]       wdata,
   input  wire             wr,
   input  wire             rd,
   output reg  [7:0]       rdata,
   // Radio status inputs (async to clk)
   input  wire             tx_active_in,
   input  wire [CNT_W:0]   rx_fifo_count,
   input  wire             filter_enable,
   input  wire             frame_filter_pass,
   input  wire             frame_complete,
   input  wire             frame_delim_in,
   input  wire             channel_clear_in,
   input  wire             ack_frame_event,
   // Power mode inputs
   input  wire             power_mode_two,
   input  wire             power_mode_three,
   // Regulator controls
   output wire             analog_reg_enable,
   output wire             digital_reg_enable,
   // Interrupt
   output wire             irq
);

////////////////////////////////////////////////////////////////////////////
// Input synchronisers: two flops before any logic
localparam NSYNC = 9;
wire [NSYNC-1:0] async_in = {tx_active_in, filter_enable, frame_filter_pass,
   frame_complete, frame_delim_in, channel_clear_in, ack_frame_event,
   power_mode_two, power_mode_three};
wire [NSYNC-1:0] sync2_q;
wire [CNT_W:0]   cnt2_q;

// Every pin level crosses here; nothing reads the first stage
two_flop_sync #(
   .W (NSYNC)
) u_pin_sync (
   .clk  (clk),
   .srst (srst),
   .d    (async_in),
   .q    (sync2_q)
);

// Fifo count from the radio side takes the same two stages
two_flop_sync #(
   .W (CNT_W+1)
) u_cnt_sync (
   .clk  (clk),
   .srst (srst),
   .d    (rx_fifo_count),
   .q    (cnt2_q)
);

// Count crosses as a bus; a one-cycle tear is tolerated as status only
wire tx_active_s  = sync2_q[8];
wire filt_en_s    = sync2_q[7];
wire filt_pass_s  = sync2_q[6];
wire frame_done_s = sync2_q[5];
wire delim_s      = sync2_q[4];
wire cca_s        = sync2_q[3];
wire ack_ev_s     = sync2_q[2];
wire pm2_s        = sync2_q[1];
wire pm3_s        = sync2_q[0];

wire ack_ev_rise;

// A held-high event counts once, on its first synchronised cycle
rise_detect u_ack_rise (
   .clk   (clk),
   .srst  (srst),
   .level (ack_ev_s),
   .rise  (ack_ev_rise)
);

////////////////////////////////////////////////////////////////////////////
// Software registers
reg [6:0]       rx_thr_q;
reg             ack_irq_en_q;
reg             pd_q;
reg [DLY_W-1:0] dly_sel_q;
reg [1:0]       irq_mask_q;

wire wr_pwr  = wr && (addr == `ADDR_RADIO_POWER_CTL);
wire wr_thr  = wr && (addr == `ADDR_RX_THRESHOLD);
wire wr_src  = wr && (addr == `ADDR_IRQ_SOURCE_SEL);
wire wr_stat = wr && (addr == `ADDR_IRQ_STATUS);
wire wr_mask = wr && (addr == `ADDR_IRQ_MASK);

////////////////////////////////////////////////////////////////////////////
// Threshold flag, held off by filtering, also set on full frame
reg  frame_ok_q;
wire above_thr = (cnt2_q > {1'b0, rx_thr_q});
wire rx_avail  = (cnt2_q != {(CNT_W+1){1'b0}});

always @(posedge clk) begin
   if (srst) begin
      frame_ok_q <= 1'b0;
   end else if (!rx_avail) begin
      frame_ok_q <= 1'b0;
   end else if (filt_pass_s || frame_done_s) begin
      frame_ok_q <= 1'b1;
   end
end

// Filtering on: count only counts once the frame passed or completed
wire thr_gate    = !filt_en_s || frame_ok_q;
wire thr_by_cnt  = above_thr && thr_gate;
// A complete frame raises the flag at any nonzero count
wire thr_by_done = frame_done_s && rx_avail;
wire rx_thr_flag = thr_by_cnt || thr_by_done;

////////////////////////////////////////////////////////////////////////////
// Regulator power-on delay
localparam PS_OFF  = 2'b00;
localparam PS_WAIT = 2'b01;
localparam PS_ON   = 2'b10;

reg [1:0]             ps_q;
reg [DLY_W+7:0]       dly_cnt_q;
reg                   dly_pd_q;
reg                   reg_ready_ev;
wire [DLY_W+7:0]      dly_load = ({{8{1'b0}}, dly_sel_q} + 1'b1)
   * {{DLY_W{1'b0}}, `DLY_STEP_CYCLES};

always @(posedge clk) begin
   if (srst) begin
      ps_q         <= PS_OFF;
      dly_cnt_q    <= {(DLY_W+8){1'b0}};
      dly_pd_q     <= 1'b1;
      reg_ready_ev <= 1'b0;
   end else begin
      reg_ready_ev <= 1'b0;
      case (ps_q)
         PS_OFF: begin
            dly_pd_q <= 1'b1;
            if (!pd_q) begin
               ps_q      <= PS_WAIT;
               dly_cnt_q <= dly_load;
            end
         end
         PS_WAIT: begin
            if (pd_q) begin
               ps_q <= PS_OFF;
            end else if (dly_cnt_q == {{(DLY_W+7){1'b0}}, 1'b1}) begin
               ps_q         <= PS_ON;
               dly_pd_q     <= 1'b0;
               reg_ready_ev <= 1'b1;
            end else begin
               dly_cnt_q <= dly_cnt_q - 1'b1;
            end
         end
         PS_ON: begin
            if (pd_q) begin
               ps_q     <= PS_OFF;
               dly_pd_q <= 1'b1;
            end
         end
         default: ps_q <= PS_OFF;
      endcase
   end
end

assign analog_reg_enable  = ~pd_q & ~dly_pd_q;
// Only the enable drops; register state lives on flops
assign digital_reg_enable = ~(pm2_s | pm3_s);

////////////////////////////////////////////////////////////////////////////
// Register writes and sticky interrupt flags
wire [1:0] irq_set = {reg_ready_ev, ack_ev_rise & ack_irq_en_q};

always @(posedge clk) begin
   if (srst) begin
      rx_thr_q     <= `RST_RX_THRESHOLD;
      ack_irq_en_q <= 1'b0;
      pd_q         <= 1'b1;
      dly_sel_q    <= `RST_POWER_CTL_DLY;
      irq_mask_q   <= 2'b00;
   end else begin
      if (wr_thr)
         rx_thr_q <= wdata[6:0];
      if (wr_src)
         ack_irq_en_q <= wdata[`IRQ_ACK_BIT];
      if (wr_pwr) begin
         pd_q      <= wdata[`PWR_PD_BIT];
         dly_sel_q <= wdata[`PWR_DLY_MSB:`PWR_DLY_LSB];
      end
      if (wr_mask)
         irq_mask_q <= wdata[1:0];
   end
end

localparam NFLAG = 2;

wire [NFLAG-1:0] irq_stat;
wire [NFLAG-1:0] irq_clr = wr_stat ? wdata[1:0] : 2'b00;

// One sticky flag per event source
genvar gi;
generate
   for (gi = 0; gi < NFLAG; gi = gi + 1) begin : g_irq_flag
      sticky_w1c_flag u_flag (
         .clk  (clk),
         .srst (srst),
         .set  (irq_set[gi]),
         .clr  (irq_clr[gi]),
         .flag (irq_stat[gi])
      );
   end
endgenerate

assign irq = |(irq_stat & irq_mask_q);

////////////////////////////////////////////////////////////////////////////
// Read path, data one cycle after the strobe
wire [7:0] status_byte = {3'b000, tx_active_s, rx_avail,
   rx_thr_flag, delim_s, cca_s};

reg [7:0] rd_mux;

// Unmapped addresses read zero rather than a neighbour's value
always @* begin
   rd_mux = `RST_ZERO8;
   case (addr)
      `ADDR_DIE_REVISION:    rd_mux = `DIE_REVISION_VAL;
      `ADDR_PART_IDENTITY:   rd_mux = `PART_IDENTITY_VAL;
      `ADDR_RADIO_STATUS:    rd_mux = status_byte;
      `ADDR_IRQ_SOURCE_SEL:  rd_mux = {7'h00, ack_irq_en_q};
      `ADDR_RADIO_POWER_CTL: rd_mux = {2'b00, dly_pd_q, pd_q,
                                       dly_sel_q};
      `ADDR_RX_THRESHOLD:    rd_mux = {1'b0, rx_thr_q};
      `ADDR_IRQ_STATUS:      rd_mux = {6'h00, irq_stat};
      `ADDR_IRQ_MASK:        rd_mux = {6'h00, irq_mask_q};
      default:               rd_mux = `RST_ZERO8;
   endcase
end

// Idle cycles read zero so a stale answer never lingers
always @(posedge clk) begin
   if (srst) begin
      rdata <= `RST_ZERO8;
   end else if (rd) begin
      rdata <= rd_mux;
   end else begin
      rdata <= `RST_ZERO8;
   end
end

endmodule // radio_status_and_regulator_ctl

////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser; only the second stage is visible outside
module two_flop_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clk,
   input  wire         srst,
   // Data
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);

reg [W-1:0] meta_q;
reg [W-1:0] stable_q;

// Both stages clear on reset, matching the idle low level of the pins
always @(posedge clk) begin
   if (srst) begin
      meta_q   <= {W{1'b0}};
      stable_q <= {W{1'b0}};
   end else begin
      meta_q   <= d;
      stable_q <= meta_q;
   end
end

assign q = stable_q;

endmodule // two_flop_sync

////////////////////////////////////////////////////////////////////////////
// Sticky event flag, cleared by writing a one
module sticky_w1c_flag (
   // Clock and reset
   input  wire clk,
   input  wire srst,
   // Event and clear
   input  wire set,
   input  wire clr,
   // Flag
   output wire flag
);

reg flag_q;
reg flag_d;

// Set beats a simultaneous write-one clear, so no event is lost
always @* begin
   flag_d = flag_q;
   if (clr) begin
      flag_d = 1'b0;
   end
   if (set) begin
      flag_d = 1'b1;
   end
end

always @(posedge clk) begin
   if (srst) begin
      flag_q <= 1'b0;
   end else begin
      flag_q <= flag_d;
   end
end

assign flag = flag_q;

endmodule // sticky_w1c_flag

////////////////////////////////////////////////////////////////////////////
// Rising-edge detector; history resets to the idle low level
module rise_detect (
   // Clock and reset
   input  wire clk,
   input  wire srst,
   // Level in, one-cycle pulse out
   input  wire level,
   output wire rise
);

reg level_q;

// A level already high at reset release gives a pulse at once, as history starts low
always @(posedge clk) begin
   if (srst) begin
      level_q <= 1'b0;
   end else begin
      level_q <= level;
   end
end

assign rise = level & ~level_q;

endmodule // rise_detect

/* radio_status_and_regulator_ctl_bench.sv */
`timescale 1ns/1ps
`include "radio_status_regs_defs.vh"
module radio_status_and_regulator_ctl_bench;
   reg        clk = 1'b0;
   reg        srst = 1'b1;
   reg [15:0] addr = 16'h0000;
   reg [7:0]  wdata = 8'h00;
   reg        wr = 1'b0;
   reg        rd = 1'b0;
   reg [7:0]  cnt = 8'h00;
   reg [5:0]  f = 6'h00;
   reg        ack = 1'b0;
   reg        pm2 = 1'b0;
   reg        pm3 = 1'b0;
   wire [7:0] rdata;
   wire       aen;
   wire       den;
   wire       irq;
   integer    error_cnt = 0;
   integer    n_checks = 0;
   integer    cyc = 0;
   integer    i;
   always #2 clk = ~clk;
   radio_status_and_regulator_ctl u_dut (.clk(clk), .srst(srst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .tx_active_in(f[5]), .rx_fifo_count(cnt), .filter_enable(f[4]),
      .frame_filter_pass(f[3]), .frame_complete(f[2]),
      .frame_delim_in(f[1]), .channel_clear_in(f[0]),
      .ack_frame_event(ack), .power_mode_two(pm2), .power_mode_three(pm3),
      .analog_reg_enable(aen), .digital_reg_enable(den), .irq(irq));
   ////////////////////////////////////////////////////////////////////////
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", n_checks, error_cnt);
         if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wrr(input [15:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   // Read data stand only in the cycle after the strobe
   task rdc(input [15:0] a, input [7:0] e);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 chk(rdata, e);
      end
   endtask
   // Inputs pass a two-flop sync, so allow a few cycles
   task st(input [7:0] c, input [5:0] fl, input [7:0] e);
      begin
         @(posedge clk);
         cnt <= c;
         f <= fl;
         repeat (4) @(posedge clk);
         rdc(`ADDR_RADIO_STATUS, e);
      end
   endtask
   task pulse_ack;
      begin
         @(posedge clk);
         ack <= 1'b1;
         repeat (4) @(posedge clk);
         ack <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_ident;
      begin
         wrr(`ADDR_DIE_REVISION, 8'h00);
         rdc(`ADDR_DIE_REVISION, `DIE_REVISION_VAL);
         rdc(`ADDR_PART_IDENTITY, `PART_IDENTITY_VAL);
         wrr(16'hDF63, 8'hFF);
         rdc(16'hDF63, 8'h00);
         rdc(`ADDR_IRQ_SOURCE_SEL, 8'h00);
         rdc(`ADDR_RX_THRESHOLD, 8'h40);
         rdc(`ADDR_RADIO_POWER_CTL, 8'h3F);
         wrr(`ADDR_RX_THRESHOLD, 8'hFF);
         rdc(`ADDR_RX_THRESHOLD, 8'h7F);
         $display("ident done");
      end
   endtask
   task t_status;
      begin
         wrr(`ADDR_RX_THRESHOLD, 8'h02);
         st(8'h00, 6'b100011, 8'h13);
         st(8'h00, 6'b000001, 8'h01);
         st(8'h00, 6'b000010, 8'h02);
         st(8'h01, 6'b000000, 8'h08);
         st(8'h02, 6'b000000, 8'h08);
         st(8'h03, 6'b000000, 8'h0C);
         st(8'h03, 6'b010000, 8'h08);
         st(8'h03, 6'b011000, 8'h0C);
         st(8'h00, 6'b000000, 8'h00);
         st(8'h01, 6'b000100, 8'h0C);
         st(8'h00, 6'b000000, 8'h00);
         $display("status done");
      end
   endtask
   task t_irq;
      begin
         wrr(`ADDR_IRQ_MASK, 8'h03);
         pulse_ack;
         rdc(`ADDR_IRQ_STATUS, 8'h00);
         wrr(`ADDR_IRQ_SOURCE_SEL, 8'hFF);
         rdc(`ADDR_IRQ_SOURCE_SEL, 8'h01);
         pulse_ack;
         rdc(`ADDR_IRQ_STATUS, 8'h01);
         chk({7'h00, irq}, 8'h01);
         wrr(`ADDR_IRQ_MASK, 8'h02);
         rdc(`ADDR_IRQ_MASK, 8'h02);
         chk({7'h00, irq}, 8'h00);
         wrr(`ADDR_IRQ_STATUS, 8'h01);
         rdc(`ADDR_IRQ_STATUS, 8'h00);
         $display("irq done");
      end
   endtask
   task t_pwr;
      begin
         wrr(`ADDR_RADIO_POWER_CTL, 8'h00);
         for (i = 0; i < 300 && aen !== 1'b1; i = i + 1)
            @(posedge clk);
         chk({7'h00, i > 60 && i < 70}, 8'h01);
         rdc(`ADDR_RADIO_POWER_CTL, 8'h00);
         rdc(`ADDR_IRQ_STATUS, 8'h02);
         chk({7'h00, irq}, 8'h01);
         wrr(`ADDR_IRQ_STATUS, 8'h02);
         wrr(`ADDR_RADIO_POWER_CTL, 8'h10);
         repeat (2) @(posedge clk);
         chk({7'h00, aen}, 8'h00);
         rdc(`ADDR_RADIO_POWER_CTL, 8'h30);
         @(posedge clk);
         pm2 <= 1'b1;
         repeat (4) @(posedge clk);
         chk({7'h00, den}, 8'h00);
         pm2 <= 1'b0;
         pm3 <= 1'b1;
         repeat (4) @(posedge clk);
         chk({7'h00, den}, 8'h00);
         pm3 <= 1'b0;
         repeat (4) @(posedge clk);
         chk({7'h00, den}, 8'h01);
         rdc(`ADDR_RX_THRESHOLD, 8'h02);
         $display("power done");
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Whole run is near 230 cycles; ceiling of 5000 leaves wide margin
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         error_cnt = error_cnt + 1;
         print_verdict;
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      t_ident;
      t_status;
      t_irq;
      t_pwr;
      print_verdict;
   end
endmodule // radio_status_and_regulator_ctl_bench

/* radio_status_checker_assertions.sv */
`timescale 1ns/1ps
`include "radio_status_regs_defs.vh"
module radio_status_checker #(
   parameter CNT_W = 7,
   parameter DLY_W = 4
) (
   // Clock, reset, register port
   input wire        clk,
   input wire        srst,
   input wire [15:0] addr,
   input wire [7:0]  wdata,
   input wire        wr,
   input wire        rd,
   input wire [7:0]  rdata,
   // Power and interrupt
   input wire        power_mode_two,
   input wire        power_mode_three,
   input wire        analog_reg_enable,
   input wire        digital_reg_enable,
   input wire        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Last cycle's strobe and address, to judge the read answer
   reg        rd_q;
   reg [15:0] a_q;
   wire       lp = power_mode_two || power_mode_three;
   wire       on = wr && addr == `ADDR_RADIO_POWER_CTL && wdata[4:0] == 5'h00;
   always @(posedge clk) begin
      rd_q <= rd;
      a_q  <= addr;
   end
   a_idle_rdata_zero: assert property (!rd_q |-> rdata == 8'h00)
      else $error("read data not zero outside answer");
   a_die_rev_value: assert property (
      rd_q && a_q == `ADDR_DIE_REVISION |-> rdata == `DIE_REVISION_VAL)
      else $error("bad die revision");
   a_part_id_value: assert property (
      rd_q && a_q == `ADDR_PART_IDENTITY |-> rdata == `PART_IDENTITY_VAL)
      else $error("bad part identity");
   a_status_upper_zero: assert property (
      rd_q && a_q == `ADDR_RADIO_STATUS |-> rdata[7:5] == 3'h0)
      else $error("status upper bits set");
   a_source_upper_zero: assert property (
      rd_q && a_q == `ADDR_IRQ_SOURCE_SEL |-> rdata[7:1] == 7'h00)
      else $error("source upper bits set");
   a_lowpower_dreg_off: assert property (
      lp [*3] |-> !digital_reg_enable)
      else $error("digital regulator on in low power");
   a_run_dreg_on: assert property (
      !lp [*3] |-> digital_reg_enable)
      else $error("digital regulator off while running");
   a_pd_write_off: assert property (
      wr && addr == `ADDR_RADIO_POWER_CTL && wdata[4]
      |=> ##1 !analog_reg_enable)
      else $error("regulator not off");
   a_power_on_delay: assert property (
      on && !analog_reg_enable |=>
      (!analog_reg_enable) [*8] ##[54:58] analog_reg_enable)
      else $error("regulator delay wrong");
   c_reg_on: cover property ($rose(analog_reg_enable));
   c_irq_on: cover property ($rose(irq));
   c_low_power: cover property ($fell(digital_reg_enable));
endmodule // radio_status_checker
bind radio_status_and_regulator_ctl radio_status_checker #(
   .CNT_W(CNT_W), .DLY_W(DLY_W)) u_chk (.clk(clk), .srst(srst),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .power_mode_two(power_mode_two), .power_mode_three(power_mode_three),
   .analog_reg_enable(analog_reg_enable),
   .digital_reg_enable(digital_reg_enable), .irq(irq));

/* radio_status_regs_defs.vh */
`ifndef RADIO_STATUS_REGS_DEFS_VH
`define RADIO_STATUS_REGS_DEFS_VH

// Register offsets
`define ADDR_DIE_REVISION      16'hDF60
`define ADDR_PART_IDENTITY     16'hDF61
`define ADDR_RADIO_STATUS      16'hDF62
`define ADDR_IRQ_SOURCE_SEL    16'hDF64
`define ADDR_RADIO_POWER_CTL   16'hDF17
`define ADDR_RX_THRESHOLD      16'hDF4F
`define ADDR_IRQ_STATUS        16'hDF70
`define ADDR_IRQ_MASK          16'hDF71

// Identity values (arbitrary)
`define DIE_REVISION_VAL       8'h5A
`define PART_IDENTITY_VAL      8'hA5

// Field positions
`define ST_TX_ACTIVE           4
`define ST_RX_AVAIL            3
`define ST_RX_THR              2
`define ST_FRAME_DELIM         1
`define ST_CHAN_CLEAR          0
`define PWR_PD_BIT             4
`define PWR_DLY_MSB            3
`define PWR_DLY_LSB            0
`define PWR_DPD_BIT            5
`define IRQ_ACK_BIT            0
`define IRQ_REG_READY_BIT      1

// Reset values
`define RST_RX_THRESHOLD       7'h40
`define RST_POWER_CTL_DLY      4'hF
`define RST_ZERO8              8'h00

// Each delay step is this many clocks
`define DLY_STEP_CYCLES        8'h40

`endif
